// [rtl/sdram_timing_pkg.sv]
package sdram_timing_pkg;

    // ----------------------------------------
    // commands and burst modes
    // ----------------------------------------
    typedef enum logic [3:0] {
        cmd_nop,
        cmd_mode_set,
        cmd_activate,
        cmd_precharge,
        cmd_refresh,
        cmd_read,
        cmd_write,
        cmd_short_cal
    } cmd_type;

    typedef enum logic [1:0] {
        burst_eight_fixed,
        burst_on_the_fly,
        burst_chop_fixed
    } burst_type;

    // ----------------------------------------
    // clock and time conversion
    // ----------------------------------------
    localparam int clk_period_ns = 10;

    // nanoseconds to whole cycles, rounded up, never below one
    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + clk_period_ns - 1) / clk_period_ns;
        return (c < 1) ? 1 : c;
    endfunction

    // ----------------------------------------
    // timing figures
    // ----------------------------------------
    localparam int mode_set_spacing           = 4;
    localparam int write_latency_cycles       = 5;
    localparam int write_tail_full            = 4;
    localparam int write_tail_chop_fixed      = 2;
    localparam int write_recovery_ns          = 15;
    localparam int write_recovery_cycles      = ceil_cycles(write_recovery_ns);
    localparam int refresh_to_powerdown_delay = 1;
    localparam int frozen_dll_exit_ns         = 24;
    localparam int frozen_dll_exit_delay      = ceil_cycles(frozen_dll_exit_ns);
    localparam int refresh_interval_ns        = 7800;
    localparam int refresh_interval           = refresh_interval_ns / clk_period_ns;
    localparam int refresh_cycle_ns           = 110;
    localparam int refresh_cycle_cycles       = ceil_cycles(refresh_cycle_ns);
    localparam int row_op_ns                  = 15;
    localparam int row_op_cycles              = ceil_cycles(row_op_ns);
    localparam int short_cal_cycles           = 64;
    localparam int short_cal_step_permille    = 5;
    localparam int short_cal_interval_default = 12800000;
    localparam int read_latency_cycles        = 6;
    localparam int mpr_burst_cycles           = 4;
    localparam int mpr_to_mode_set_cycles     = 2;

    // ----------------------------------------
    // address field layout
    // ----------------------------------------
    localparam int addr_width        = 16;
    localparam int mode_sel_lsb      = 14;
    localparam int burst_mode_lsb    = 0;
    localparam int wr_cycles_lsb     = 8;
    localparam int wr_cycles_width   = 5;
    localparam int mpr_enable_bit    = 2;
    localparam int autoprecharge_bit = 10;
    localparam logic [1:0] mode_sel_first = 2'h0;
    localparam logic [1:0] mode_sel_mpr   = 2'h3;
    localparam logic [wr_cycles_width-1:0] wr_cycles_reset = 5'h05;

    function automatic int write_tail(input burst_type b);
        return (b == burst_chop_fixed) ? write_tail_chop_fixed : write_tail_full;
    endfunction

    function automatic logic [7:0] load_count(input int n);
        return 8'(n - 1);
    endfunction

endpackage

// [rtl/sdram_cmd_if.sv]
interface sdram_cmd_if (
    input wire logic clock,
    input wire logic rstn
);
    logic                                        cke;
    sdram_timing_pkg::cmd_type                   cmd;
    logic [sdram_timing_pkg::addr_width-1:0]     addr;

    modport ctrl (input clock, input rstn, output cke, output cmd, output addr);
    modport dram (input clock, input rstn, input cke, input cmd, input addr);
endinterface

// [rtl/dram_timing_end.sv]
module dram_timing_end (
    sdram_cmd_if.dram                            bus,
    output logic                                 write_start,
    output logic                                 ap_done,
    output logic                                 powerdown_reached,
    output logic                                 short_cal_busy,
    output logic                                 short_cal_done,
    output logic                                 mpr_enabled,
    output logic [sdram_timing_pkg::wr_cycles_width-1:0] wr_cycles
);
    import sdram_timing_pkg::*;

    localparam int ws_len = write_latency_cycles + write_tail_full;

    logic                       take;
    burst_type                  burst_mode_q;
    logic [wr_cycles_width-1:0] wr_cycles_q;
    logic                       mpr_enabled_q;
    logic [ws_len-1:0]          ws_pipe_q;
    logic [7:0]                 ap_cnt_q;
    logic [7:0]                 op_cnt_q;
    logic [7:0]                 zq_cnt_q;
    logic                       ap_done_q;
    logic                       pd_q;
    logic                       zq_done_q;

    // commands count only on edges where clock enable is sampled high
    assign take = bus.cke;

    // ----------------------------------------
    // mode registers
    // ----------------------------------------
    always_ff @(posedge bus.clock or negedge bus.rstn) begin
        if (!bus.rstn) begin
            burst_mode_q  <= burst_eight_fixed;
            wr_cycles_q   <= wr_cycles_reset;
            mpr_enabled_q <= 1'b0;
        end else if (take && bus.cmd == cmd_mode_set) begin
            if (bus.addr[mode_sel_lsb +: 2] == mode_sel_first) begin
                burst_mode_q <= burst_type'(bus.addr[burst_mode_lsb +: 2]);
                wr_cycles_q  <= bus.addr[wr_cycles_lsb +: wr_cycles_width];
            end else if (bus.addr[mode_sel_lsb +: 2] == mode_sel_mpr) begin
                mpr_enabled_q <= bus.addr[mpr_enable_bit];
            end
        end
    end

    // ----------------------------------------
    // internal write start and auto-precharge
    // ----------------------------------------
    // a shift line, not a counter, so back to back writes each keep their slot
    always_ff @(posedge bus.clock or negedge bus.rstn) begin
        if (!bus.rstn) begin
            ws_pipe_q <= '0;
        end else begin
            ws_pipe_q <= ws_pipe_q >> 1;
            if (take && bus.cmd == cmd_write) begin
                ws_pipe_q[write_latency_cycles + write_tail(burst_mode_q) - 1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge bus.clock or negedge bus.rstn) begin
        if (!bus.rstn) begin
            ap_cnt_q  <= 8'h00;
            ap_done_q <= 1'b0;
        end else begin
            ap_done_q <= (ap_cnt_q == 8'h01);
            if (take && bus.cmd == cmd_write && bus.addr[autoprecharge_bit]) begin
                ap_cnt_q <= 8'(write_latency_cycles + write_tail(burst_mode_q))
                            + 8'(wr_cycles_q);
            end else if (ap_cnt_q != 8'h00) begin
                ap_cnt_q <= ap_cnt_q - 8'h01;
            end
        end
    end

    // ----------------------------------------
    // row operations and refresh in progress
    // ----------------------------------------
    always_ff @(posedge bus.clock or negedge bus.rstn) begin
        if (!bus.rstn) begin
            op_cnt_q <= 8'h00;
        end else if (take && bus.cmd == cmd_refresh) begin
            op_cnt_q <= 8'(refresh_cycle_cycles);
        end else if (take && (bus.cmd == cmd_activate || bus.cmd == cmd_precharge)
                     && op_cnt_q < 8'(row_op_cycles)) begin
            op_cnt_q <= 8'(row_op_cycles);
        end else if (op_cnt_q != 8'h00) begin
            op_cnt_q <= op_cnt_q - 8'h01;
        end
    end

    // low current only once the row/refresh, auto-precharge and calibration counts have drained; the write start line is not waited for
    always_ff @(posedge bus.clock or negedge bus.rstn) begin
        if (!bus.rstn) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= !bus.cke && op_cnt_q == 8'h00 && ap_cnt_q == 8'h00
                    && zq_cnt_q == 8'h00;
        end
    end

    // ----------------------------------------
    // short impedance calibration
    // ----------------------------------------
    // each run corrects short_cal_step_permille of error; the step is fixed
    always_ff @(posedge bus.clock or negedge bus.rstn) begin
        if (!bus.rstn) begin
            zq_cnt_q  <= 8'h00;
            zq_done_q <= 1'b0;
        end else begin
            zq_done_q <= (zq_cnt_q == 8'h01);
            if (take && bus.cmd == cmd_short_cal) begin
                // the taking edge is the first of the run, so done lands on edge 64
                zq_cnt_q <= 8'(short_cal_cycles - 1);
            end else if (zq_cnt_q != 8'h00) begin
                zq_cnt_q <= zq_cnt_q - 8'h01;
            end
        end
    end

    assign write_start       = ws_pipe_q[0];
    assign ap_done           = ap_done_q;
    assign powerdown_reached = pd_q;
    assign short_cal_busy    = (zq_cnt_q != 8'h00);
    assign short_cal_done    = zq_done_q;
    assign mpr_enabled       = mpr_enabled_q;
    assign wr_cycles         = wr_cycles_q;
endmodule

// [rtl/dram_ctrl_end.sv]
module dram_ctrl_end #(
    parameter int short_cal_interval = sdram_timing_pkg::short_cal_interval_default
) (
    input  wire logic                                    clock,
    input  wire logic                                    rstn,
    sdram_cmd_if.ctrl                                    bus,
    input  wire logic                                    req_valid,
    input  wire sdram_timing_pkg::cmd_type               req_cmd,
    input  wire logic [sdram_timing_pkg::addr_width-1:0] req_addr,
    output logic                                         req_ready,
    input  wire logic                                    pd_req,
    input  wire logic                                    dll_frozen_pd,
    output logic                                         in_powerdown,
    output logic                                         refresh_pending
);
    import sdram_timing_pkg::*;

    typedef enum {st_run, st_powerdown} state_type;

    state_type                  state_q;
    logic                       cke_q;
    cmd_type                    cmd_q;
    logic [addr_width-1:0]      addr_q;
    burst_type                  burst_mode_q;
    logic [wr_cycles_width-1:0] wr_cycles_q;
    logic                       mpr_on_q;
    logic [7:0]                 mrs_cnt_q;
    logic [7:0]                 wr_pd_cnt_q;
    logic [7:0]                 ref_pd_cnt_q;
    logic [7:0]                 dll_cnt_q;
    logic [7:0]                 mpr_cnt_q;
    logic [7:0]                 busy_cnt_q;
    logic [9:0]                 refi_cnt_q;
    logic [31:0]                zq_cnt_q;
    logic                       refresh_due_q;
    logic                       zq_due_q;
    logic                       can_issue;
    logic                       allowed;
    logic                       issue;
    cmd_type                    issue_cmd;
    logic [addr_width-1:0]      issue_addr;
    logic                       enter_pd;
    logic                       leave_pd;

    // ----------------------------------------
    // issue selection
    // ----------------------------------------
    assign can_issue = state_q == st_run && cke_q && busy_cnt_q == 8'h00;

    always_comb begin
        unique case (req_cmd)
            cmd_mode_set: begin
                allowed = mrs_cnt_q == 8'h00
                          && (req_addr[mode_sel_lsb +: 2] != mode_sel_mpr
                              || mpr_cnt_q == 8'h00);
            end
            cmd_read: begin
                allowed = dll_cnt_q == 8'h00;
            end
            default: begin
                allowed = 1'b1;
            end
        endcase
    end

    // refresh and calibration go ahead of user traffic
    assign req_ready = can_issue && !refresh_due_q && !zq_due_q && allowed;

    always_comb begin
        issue      = 1'b0;
        issue_cmd  = cmd_nop;
        issue_addr = '0;
        if (can_issue && refresh_due_q) begin
            issue     = 1'b1;
            issue_cmd = cmd_refresh;
        end else if (can_issue && zq_due_q) begin
            issue     = 1'b1;
            issue_cmd = cmd_short_cal;
        end else if (req_valid && req_ready) begin
            issue      = 1'b1;
            issue_cmd  = req_cmd;
            issue_addr = req_addr;
        end
    end

    // ----------------------------------------
    // power-down entry and exit
    // ----------------------------------------
    assign enter_pd = state_q == st_run && cke_q && pd_req && !issue
                      && !refresh_due_q && !zq_due_q && busy_cnt_q == 8'h00
                      && mrs_cnt_q == 8'h00
                      && wr_pd_cnt_q == 8'h00
                      && ref_pd_cnt_q == 8'h00;
    // a due refresh pulls the link out of power-down, whatever the user wants
    assign leave_pd = state_q == st_powerdown && (!pd_req || refresh_due_q || zq_due_q);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= st_run;
            cke_q   <= 1'b1;
        end else begin
            unique case (state_q)
                st_run: begin
                    if (enter_pd) begin
                        state_q <= st_powerdown;
                        cke_q   <= 1'b0;
                    end
                end
                st_powerdown: begin
                    if (leave_pd) begin
                        state_q <= st_run;
                        cke_q   <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // command outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmd_q  <= cmd_nop;
            addr_q <= '0;
        end else begin
            cmd_q  <= issue_cmd;
            addr_q <= issue_addr;
        end
    end

    // ----------------------------------------
    // mirror of the device mode state
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            burst_mode_q <= burst_eight_fixed;
            wr_cycles_q  <= wr_cycles_reset;
            mpr_on_q     <= 1'b0;
        end else if (issue && issue_cmd == cmd_mode_set) begin
            if (issue_addr[mode_sel_lsb +: 2] == mode_sel_first) begin
                burst_mode_q <= burst_type'(issue_addr[burst_mode_lsb +: 2]);
                wr_cycles_q  <= issue_addr[wr_cycles_lsb +: wr_cycles_width];
            end else if (issue_addr[mode_sel_lsb +: 2] == mode_sel_mpr) begin
                mpr_on_q <= issue_addr[mpr_enable_bit];
            end
        end
    end

    // ----------------------------------------
    // spacing counters, one per constraint
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mrs_cnt_q  <= 8'h00;
            busy_cnt_q <= 8'h00;
            mpr_cnt_q  <= 8'h00;
        end else begin
            if (issue && issue_cmd == cmd_mode_set) begin
                mrs_cnt_q <= load_count(mode_set_spacing);
            end else if (mrs_cnt_q != 8'h00) begin
                mrs_cnt_q <= mrs_cnt_q - 8'h01;
            end
            if (issue && issue_cmd == cmd_refresh) begin
                busy_cnt_q <= load_count(refresh_cycle_cycles);
            end else if (issue && issue_cmd == cmd_short_cal) begin
                busy_cnt_q <= load_count(short_cal_cycles);
            end else if (busy_cnt_q != 8'h00) begin
                busy_cnt_q <= busy_cnt_q - 8'h01;
            end
            if (issue && issue_cmd == cmd_read && mpr_on_q) begin
                mpr_cnt_q <= load_count(read_latency_cycles + mpr_burst_cycles
                                        + mpr_to_mode_set_cycles);
            end else if (mpr_cnt_q != 8'h00) begin
                mpr_cnt_q <= mpr_cnt_q - 8'h01;
            end
        end
    end

    // with auto-precharge the programmed recovery plus one edge applies
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_pd_cnt_q <= 8'h00;
        end else if (issue && issue_cmd == cmd_write && issue_addr[autoprecharge_bit]) begin
            wr_pd_cnt_q <= load_count(write_latency_cycles + write_tail(burst_mode_q)
                                      + int'(wr_cycles_q) + 1);
        end else if (issue && issue_cmd == cmd_write) begin
            wr_pd_cnt_q <= load_count(write_latency_cycles + write_tail(burst_mode_q)
                                      + write_recovery_cycles);
        end else if (wr_pd_cnt_q != 8'h00) begin
            wr_pd_cnt_q <= wr_pd_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_pd_cnt_q <= 8'h00;
            dll_cnt_q    <= 8'h00;
        end else begin
            if (issue && issue_cmd == cmd_refresh) begin
                ref_pd_cnt_q <= dll_frozen_pd
                    ? load_count(refresh_to_powerdown_delay + frozen_dll_exit_delay)
                    : load_count(refresh_to_powerdown_delay);
            end else if (ref_pd_cnt_q != 8'h00) begin
                ref_pd_cnt_q <= ref_pd_cnt_q - 8'h01;
            end
            if (leave_pd && dll_frozen_pd) begin
                dll_cnt_q <= load_count(frozen_dll_exit_delay);
            end else if (dll_cnt_q != 8'h00) begin
                dll_cnt_q <= dll_cnt_q - 8'h01;
            end
        end
    end

    // ----------------------------------------
    // refresh and calibration schedules
    // ----------------------------------------
    // these run in power-down too, so a stretched stay never starves refresh
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            refi_cnt_q    <= 10'(refresh_interval - 1);
            refresh_due_q <= 1'b0;
        end else begin
            if (refi_cnt_q == 10'h000) begin
                refi_cnt_q    <= 10'(refresh_interval - 1);
                refresh_due_q <= 1'b1;
            end else begin
                refi_cnt_q <= refi_cnt_q - 10'h001;
                if (issue && issue_cmd == cmd_refresh) begin
                    refresh_due_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            zq_cnt_q <= 32'(short_cal_interval - 1);
            zq_due_q <= 1'b0;
        end else begin
            if (zq_cnt_q == 32'h0000_0000) begin
                zq_cnt_q <= 32'(short_cal_interval - 1);
                zq_due_q <= 1'b1;
            end else begin
                zq_cnt_q <= zq_cnt_q - 32'h0000_0001;
                if (issue && issue_cmd == cmd_short_cal) begin
                    zq_due_q <= 1'b0;
                end
            end
        end
    end

    assign bus.cke         = cke_q;
    assign bus.cmd         = cmd_q;
    assign bus.addr        = addr_q;
    assign in_powerdown    = state_q == st_powerdown;
    assign refresh_pending = refresh_due_q;
endmodule

// [tb/sdram_timing_assertions.sv]
module sdram_timing_assertions (
    input wire logic                                    clock,
    input wire logic                                    rstn,
    input wire logic                                    cke,
    input wire sdram_timing_pkg::cmd_type               cmd,
    input wire logic [sdram_timing_pkg::addr_width-1:0] addr
);
    timeunit 1ns;
    timeprecision 1ns;
    import sdram_timing_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    // chop-fixed tail is the shortest legal write-to-powerdown span
    localparam int wr_min  = write_latency_cycles + write_tail_chop_fixed + write_recovery_cycles;
    // slack: a due refresh may wait behind a calibration
    localparam int ref_max = refresh_interval + 100;
    logic [7:0]  wr_age_q;
    logic [11:0] ref_age_q;
    logic        mpr_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) wr_age_q <= 8'hff;
        else if (cmd == cmd_write) wr_age_q <= 8'h01;
        else if (wr_age_q != 8'hff) wr_age_q <= wr_age_q + 8'h01;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) ref_age_q <= 12'h000;
        else if (cmd == cmd_refresh) ref_age_q <= 12'h000;
        else ref_age_q <= ref_age_q + 12'h001;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) mpr_q <= 1'b0;
        else if (cmd == cmd_mode_set && addr[15:14] == mode_sel_mpr) mpr_q <= addr[mpr_enable_bit];
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence quiet8;
        (cmd == cmd_nop)[*8];
    endsequence
    sequence mpr_read;
        mpr_q && cmd == cmd_read;
    endsequence
    sequence mpr_quiet8;
        (!(cmd == cmd_mode_set && addr[15:14] == mode_sel_mpr))[*8];
    endsequence
    chk_mode_set_spacing: assert property (cmd == cmd_mode_set |=> (cmd != cmd_mode_set)[*3])
        else $error("mode-set spacing too short");
    chk_refresh_busy: assert property (cmd == cmd_refresh |=> quiet8)
        else $error("command during refresh");
    chk_cal_busy: assert property (cmd == cmd_short_cal |=> quiet8)
        else $error("command during short calibration");
    chk_refresh_to_pd: assert property (cmd == cmd_refresh |=> cke[*8])
        else $error("clock enable dropped too soon after refresh");
    chk_write_to_pd: assert property ($fell(cke) |-> wr_age_q >= wr_min)
        else $error("clock enable dropped too soon after write");
    chk_idle_cke_low: assert property (!cke |-> cmd == cmd_nop)
        else $error("command while clock enable low");
    chk_mpr_gap: assert property (mpr_read |=> mpr_quiet8)
        else $error("mode-set too soon after multipurpose read");
    chk_refresh_on_time: assert property (ref_age_q <= ref_max)
        else $error("refresh interval exceeded");
endmodule

// [tb/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sdram_timing_pkg::*;
    logic        clock = 0;
    logic        rstn = 0;
    logic        req_valid = 0;
    cmd_type     req_cmd = cmd_nop;
    logic [15:0] req_addr = 16'h0000;
    logic        pd_req = 0;
    logic        dll_frozen_pd = 0;
    logic        req_ready, in_powerdown, refresh_pending;
    logic        write_start, ap_done, powerdown_reached;
    logic        short_cal_busy, short_cal_done, mpr_enabled;
    logic [4:0]  wr_cycles;
    logic        cke_q = 1;
    int          cyc, t_ms0, t_ws, t_ap, t_cd, t_fall, t_rise, n_ref;
    int          tc[16];
    int          miscompares, check_count;
    localparam int cal_gap = 1000;
    always #5 clock = ~clock;
    sdram_cmd_if u_sdram_cmd_if (.clock(clock), .rstn(rstn));
    wire cmd_type bc = u_sdram_cmd_if.cmd;
    wire          bke = u_sdram_cmd_if.cke;
    // long calibration spacing keeps automatic calibrations out of the measured spans
    dram_ctrl_end #(.short_cal_interval(cal_gap)) u_dram_ctrl_end (
        .clock(clock), .rstn(rstn), .bus(u_sdram_cmd_if.ctrl), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_addr(req_addr), .req_ready(req_ready), .pd_req(pd_req),
        .dll_frozen_pd(dll_frozen_pd), .in_powerdown(in_powerdown),
        .refresh_pending(refresh_pending));
    dram_timing_end u_dram_timing_end (
        .bus(u_sdram_cmd_if.dram), .write_start(write_start), .ap_done(ap_done),
        .powerdown_reached(powerdown_reached), .short_cal_busy(short_cal_busy),
        .short_cal_done(short_cal_done), .mpr_enabled(mpr_enabled), .wr_cycles(wr_cycles));
    sdram_timing_assertions u_sdram_timing_assertions (
        .clock(clock), .rstn(rstn), .cke(u_sdram_cmd_if.cke), .cmd(u_sdram_cmd_if.cmd),
        .addr(u_sdram_cmd_if.addr));
    // ----------------------------------------
    // bus monitor: cycle stamps of events
    // ----------------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        tc[bc] <= cyc;
        if (bc == cmd_mode_set) t_ms0 <= tc[cmd_mode_set];
        if (bc == cmd_refresh) n_ref <= n_ref + 1;
        if (write_start) t_ws <= cyc;
        if (ap_done) t_ap <= cyc;
        if (short_cal_done) t_cd <= cyc;
        if (cke_q && !bke) t_fall <= cyc;
        if (!cke_q && bke) t_rise <= cyc;
        cke_q <= bke;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic issue(input cmd_type c, input logic [15:0] a);
        int n;
        n = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        forever begin
            @(negedge clock);
            n++;
            if (req_ready === 1'b1 || n > 500) break;
        end
        @(posedge clock);
        req_valid <= 1'b0;
        if (n > 500) miscompares++;
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        check("wr_cycles reset", wr_cycles, 5);
        check("mpr reset", mpr_enabled, 0);
        check("pd idle", powerdown_reached, 0);
        for (int b = 0; b < 3; b++) begin
            issue(cmd_mode_set, {8'h06, 6'h00, 2'(b)});
            issue(cmd_write, 16'h0400);
            repeat (60) @(posedge clock);
            check("write_start", t_ws - tc[cmd_write], 5 + (b == 2 ? 2 : 4));
            check("ap_done", t_ap - tc[cmd_write], 5 + (b == 2 ? 2 : 4) + 6 + 1);
            check("wr_cycles", wr_cycles, 6);
        end
        issue(cmd_mode_set, 16'h0602);
        issue(cmd_mode_set, 16'h0602);
        repeat (10) @(posedge clock);
        check("mode-set spacing", tc[cmd_mode_set] - t_ms0, 4);
        issue(cmd_short_cal, 16'h0000);
        @(posedge clock);
        @(negedge clock);
        check("cal busy", short_cal_busy, 1);
        repeat (80) @(posedge clock);
        check("cal done", t_cd - tc[cmd_short_cal], 64);
        issue(cmd_write, 16'h0000);
        pd_req <= 1'b1;
        dll_frozen_pd <= 1'b1;
        repeat (40) @(posedge clock);
        check("in_powerdown", in_powerdown, 1);
        check("cke low", bke, 0);
        check("powerdown_reached", powerdown_reached, 1);
        check("write to pd", t_fall - tc[cmd_write] >= 9, 1);
        pd_req <= 1'b0;
        issue(cmd_read, 16'h0000);
        repeat (10) @(posedge clock);
        check("exit to read", tc[cmd_read] - t_rise >= 3, 1);
        issue(cmd_mode_set, 16'hc004);
        repeat (5) @(posedge clock);
        check("mpr on", mpr_enabled, 1);
        issue(cmd_read, 16'h0000);
        issue(cmd_mode_set, 16'hc000);
        repeat (10) @(posedge clock);
        check("mpr gap", tc[cmd_mode_set] - tc[cmd_read] >= 12, 1);
        check("mpr off", mpr_enabled, 0);
        repeat (900) @(posedge clock);
        check("refresh issued", n_ref > 0, 1);
        check("refresh cleared", refresh_pending, 0);
        // reset leaves at stamp 9; due cal_gap edges on, on the bus one later, stamped by the monitor two later
        check("auto cal", tc[cmd_short_cal], cal_gap + 11);
        report_and_stop();
    end
endmodule
